// file: core/boundary_scan_tap.sv
// boundary_scan_tap: boundary-scan test port with bypass and pin cells
// assumes: tck_i from the board test controller, may stop between frames;
// sys_clk_i runs free; arst_n_i resets both domains
`timescale 1ns/1ps
module boundary_scan_tap #(
  parameter int BSR_LEN    = scan_pkg::BSR_LEN_DEF,
  parameter int FIFO_DEPTH = scan_pkg::FIFO_DEPTH_DEF,
  parameter int NPIN       = BSR_LEN / scan_pkg::CELLS_PER_PIN
) (
  input  wire logic            sys_clk_i,
  input  wire logic            arst_n_i,
  input  wire logic            tck_i,
  input  wire logic            tms_i,
  input  wire logic            tms_drive_i,
  input  wire logic            tdi_i,
  input  wire logic            tdi_drive_i,
  output logic                 tdo_o,
  output logic                 tdo_oe_o,
  input  wire logic [NPIN-1:0] pin_in_i,
  input  wire logic [NPIN-1:0] core_out_i,
  input  wire logic [NPIN-1:0] core_oe_i,
  output logic      [NPIN-1:0] pin_out_o,
  output logic      [NPIN-1:0] pin_oe_o,
  input  wire logic            drive_ready_i,
  output logic                 ext_test_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // variant lengths only
  if (BSR_LEN != 273 && BSR_LEN != 417 && BSR_LEN != 465 &&
      BSR_LEN != 645) begin : g_len_chk
    $error("boundary length must be 273, 417, 465 or 645");
  end
  if (NPIN * scan_pkg::CELLS_PER_PIN != BSR_LEN) begin : g_pin_chk
    $error("pin count must match boundary length");
  end

  // ----------------------------------------------------------------
  // test port inputs
  // ----------------------------------------------------------------
  logic tms_eff;
  logic tdi_eff;

  assign tms_eff = tms_drive_i ? tms_i : 1'b1;
  assign tdi_eff = tdi_drive_i ? tdi_i : 1'b1;

  // ----------------------------------------------------------------
  // test clock domain: state machine
  // ----------------------------------------------------------------
  scan_pkg::tap_state_type state_r;
  scan_pkg::tap_state_type state_nxt;

  assign state_nxt = scan_pkg::tap_next(state_r, tms_eff);

  // state register
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= scan_pkg::TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // state decodes
  logic in_tlr;
  logic cap_ir;
  logic shift_ir;
  logic upd_ir;
  logic cap_dr;
  logic shift_dr;
  logic upd_dr;

  assign in_tlr   = (state_r == scan_pkg::TLR);
  assign cap_ir   = (state_r == scan_pkg::CAP_IR);
  assign shift_ir = (state_r == scan_pkg::SHIFT_IR);
  assign upd_ir   = (state_r == scan_pkg::UPD_IR);
  assign cap_dr   = (state_r == scan_pkg::CAP_DR);
  assign shift_dr = (state_r == scan_pkg::SHIFT_DR);
  assign upd_dr   = (state_r == scan_pkg::UPD_DR);

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [scan_pkg::IR_LEN-1:0] ir_shift_r;
  logic [scan_pkg::IR_LEN-1:0] ir_r;
  logic                        sel_extest;
  logic                        sel_sample;
  logic                        sel_bypass;

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_shift_r <= scan_pkg::IR_CAPTURE;
    end else if (cap_ir) begin
      ir_shift_r <= scan_pkg::IR_CAPTURE;
    end else if (shift_ir) begin
      ir_shift_r <= {tdi_eff, ir_shift_r[scan_pkg::IR_LEN-1:1]};
    end
  end

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ir_r <= scan_pkg::OP_BYPASS;
    end else if (in_tlr) begin
      ir_r <= scan_pkg::OP_BYPASS;
    end else if (upd_ir) begin
      ir_r <= ir_shift_r;
    end
  end

  assign sel_extest = (ir_r == scan_pkg::OP_EXTEST);
  assign sel_sample = (ir_r == scan_pkg::OP_SAMPLE);
  assign sel_bypass = !(sel_extest || sel_sample);

  // ----------------------------------------------------------------
  // bypass and boundary shift chains
  // ----------------------------------------------------------------
  logic               bypass_r;
  logic [BSR_LEN-1:0] bsr_r;
  logic [BSR_LEN-1:0] upd_r;
  logic               upd_tgl_r;
  logic [BSR_LEN-1:0] snap_tck_r;

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bypass_r <= 1'b0;
    end else if (cap_dr && sel_bypass) begin
      bypass_r <= 1'b0;
    end else if (shift_dr && sel_bypass) begin
      bypass_r <= tdi_eff;
    end
  end

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bsr_r <= '0;
    end else if (cap_dr && !sel_bypass) begin
      bsr_r <= snap_tck_r;
    end else if (shift_dr && !sel_bypass) begin
      bsr_r <= {tdi_eff, bsr_r[BSR_LEN-1:1]};
    end
  end

  // hold shifted pattern in update cells
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_r     <= '0;
      upd_tgl_r <= 1'b0;
    end else if (upd_dr && !sel_bypass) begin
      upd_r     <= bsr_r;
      upd_tgl_r <= !upd_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // serial output, changed on the falling test clock edge
  // ----------------------------------------------------------------
  logic tdo_mux;
  logic tdo_r;
  logic tdo_oe_r;

  assign tdo_mux = shift_ir   ? ir_shift_r[0] :
                   sel_bypass ? bypass_r      : bsr_r[0];

  // bypass data leaves half a cycle later
  always_ff @(negedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= tdo_mux;
      tdo_oe_r <= shift_ir || shift_dr;
    end
  end

  assign tdo_o    = tdo_r;
  assign tdo_oe_o = tdo_oe_r;

  // ----------------------------------------------------------------
  // snapshot handshake, system side to test clock side
  // ----------------------------------------------------------------
  logic [NPIN-1:0]    pin_s;
  logic [BSR_LEN-1:0] cap_w;
  logic [BSR_LEN-1:0] snap_sys_r;
  logic               snap_req_r;
  logic               snap_ack_r;
  logic               snap_req_s;
  logic               snap_ack_s;

  // pads are asynchronous to the system clock
  sync3 #(.WIDTH(NPIN)) u_pin_sync (
    .clk_i    (sys_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (pin_in_i),
    .q_o      (pin_s)
  );

  // cell order per pin: input, output data, output enable
  for (genvar k = 0; k < NPIN; k++) begin : g_cap
    assign cap_w[k*scan_pkg::CELLS_PER_PIN + scan_pkg::CELL_IN]  = pin_s[k];
    assign cap_w[k*scan_pkg::CELLS_PER_PIN + scan_pkg::CELL_OUT] =
      core_out_i[k];
    assign cap_w[k*scan_pkg::CELLS_PER_PIN + scan_pkg::CELL_OE]  =
      core_oe_i[k];
  end

  // sample taken only, core path untouched
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_sys_r <= '0;
      snap_req_r <= 1'b0;
    end else if (snap_ack_s == snap_req_r) begin
      snap_sys_r <= cap_w;
      snap_req_r <= !snap_req_r;
    end
  end

  sync3 #(.WIDTH(1)) u_req_sync (
    .clk_i    (tck_i),
    .arst_n_i (arst_n_i),
    .d_i      (snap_req_r),
    .q_o      (snap_req_s)
  );

  // word is stable while the request is outstanding
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_tck_r <= '0;
      snap_ack_r <= 1'b0;
    end else if (snap_req_s != snap_ack_r) begin
      snap_tck_r <= snap_sys_r;
      snap_ack_r <= !snap_ack_r;
    end
  end

  sync3 #(.WIDTH(1)) u_ack_sync (
    .clk_i    (sys_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (snap_ack_r),
    .q_o      (snap_ack_s)
  );

  // ----------------------------------------------------------------
  // update words and mode, test clock side to system side
  // ----------------------------------------------------------------
  logic               upd_s;
  logic               upd_seen_r;
  logic               upd_edge;
  logic               pend_r;
  logic               pend_nxt;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [BSR_LEN-1:0] fifo_out_data;
  logic               ext_s;

  sync3 #(.WIDTH(1)) u_upd_sync (
    .clk_i    (sys_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (upd_tgl_r),
    .q_o      (upd_s)
  );

  // mode level crosses to the pin side
  sync3 #(.WIDTH(1)) u_ext_sync (
    .clk_i    (sys_clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (sel_extest),
    .q_o      (ext_s)
  );

  // a new update wins over acceptance of the old one
  assign upd_edge = (upd_s != upd_seen_r);
  assign pend_nxt = upd_edge || (pend_r && !fifo_in_ready);

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      upd_seen_r <= 1'b0;
      pend_r     <= 1'b0;
    end else begin
      upd_seen_r <= upd_s;
      pend_r     <= pend_nxt;
    end
  end

  // pending word waits here while the buffer is full
  word_fifo #(.WIDTH(BSR_LEN), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (pend_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (upd_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drive_ready_i),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] drv_r;
  logic [NPIN-1:0]    drv_out;
  logic [NPIN-1:0]    drv_oe;
  logic [NPIN-1:0]    pin_out_r;
  logic [NPIN-1:0]    pin_oe_r;
  logic               ext_r;

  // pattern last taken from the buffer kept ready for driving
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_r <= '0;
    end else if (fifo_out_valid && drive_ready_i) begin
      drv_r <= fifo_out_data;
    end
  end

  for (genvar k = 0; k < NPIN; k++) begin : g_drv
    assign drv_out[k] =
      drv_r[k*scan_pkg::CELLS_PER_PIN + scan_pkg::CELL_OUT];
    assign drv_oe[k]  =
      drv_r[k*scan_pkg::CELLS_PER_PIN + scan_pkg::CELL_OE];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      ext_r     <= 1'b0;
    end else begin
      pin_out_r <= ext_s ? drv_out : core_out_i;
      pin_oe_r  <= ext_s ? drv_oe  : core_oe_i;
      ext_r     <= ext_s;
    end
  end

  assign pin_out_o  = pin_out_r;
  assign pin_oe_o   = pin_oe_r;
  assign ext_test_o = ext_r;

endmodule

// file: core/scan_pkg.sv
// scan_pkg: constants, state type and state decoder for the test port
// assumes: shared by the test port top, the bench and scan_monitor in verif/
//
// Function
// - instruction register is three bits; controller shifts exactly three.
// - sample/preload captures pin values without disturbing normal operation.
// - sample/preload also loads a shifted pattern held for pin driving.
// - external test drives update cells to pins, captures input pins.
// - bypass puts one flip-flop between serial in and serial out.
// - bypass passes data in step and leaves the core running.
// - boundary length is per variant: 273, 417, 465 or 645 cells.
// - mode select and serial in each have a weak pull-up; undriven reads high.
package scan_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int       IR_LEN      = 3;
  localparam bit [2:0] OP_EXTEST   = 3'h0;
  localparam bit [2:0] OP_SAMPLE   = 3'h5;
  localparam bit [2:0] OP_BYPASS   = 3'h7;
  localparam bit [2:0] IR_CAPTURE  = 3'h1;   // fixed 01 in the low bits

  // ----------------------------------------------------------------
  // boundary register layout
  // ----------------------------------------------------------------
  localparam int BSR_LEN_DEF  = 273;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN      = 0;           // pin input cell
  localparam int CELL_OUT     = 1;           // output data cell
  localparam int CELL_OE      = 2;           // output enable cell
  localparam int FIFO_DEPTH_DEF = 8;

  // ----------------------------------------------------------------
  // test access state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR, RTI,
    SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_type;

  // next state from current state and mode select
  function automatic tap_state_type tap_next(input tap_state_type s,
                                             input logic tms);
    unique case (s)
      TLR:      tap_next = tms ? TLR      : RTI;
      RTI:      tap_next = tms ? SEL_DR   : RTI;
      SEL_DR:   tap_next = tms ? SEL_IR   : CAP_DR;
      CAP_DR:   tap_next = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: tap_next = tms ? UPD_DR   : PAUSE_DR;
      PAUSE_DR: tap_next = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: tap_next = tms ? UPD_DR   : SHIFT_DR;
      UPD_DR:   tap_next = tms ? SEL_DR   : RTI;
      SEL_IR:   tap_next = tms ? TLR      : CAP_IR;
      CAP_IR:   tap_next = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: tap_next = tms ? UPD_IR   : PAUSE_IR;
      PAUSE_IR: tap_next = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: tap_next = tms ? UPD_IR   : SHIFT_IR;
      UPD_IR:   tap_next = tms ? SEL_DR   : RTI;
    endcase
  endfunction

endpackage

// file: core/sync3.sv
// sync3: three-stage synchroniser with agreement filter
// assumes: d_i is asynchronous to clk_i; bits are independent levels
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] q_r;

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    end
  end

  assign q_o = q_r;

endmodule

// file: core/word_fifo.sv
// word_fifo: single-clock buffer with valid/ready on both sides
// assumes: one clock; DEPTH a power of two, at least two
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("word_fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rptr_r];

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      wptr_r <= wptr_r + AW'(push);
      rptr_r <= rptr_r + AW'(pop);
      cnt_r  <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// file: verif/boundary_scan_tap_tb.sv
// boundary_scan_tap_tb: self-checking bench for the scan port
// assumes: scan_ctl drives the port; scan_monitor is bound in
`timescale 1ns/1ps
module boundary_scan_tap_tb;
  // --------------------------------------------------------------
  // signals and instances
  // --------------------------------------------------------------
  localparam int BSR  = 273;
  localparam int NPIN = BSR / scan_pkg::CELLS_PER_PIN;
  typedef struct {string nm; logic [511:0] v;} note_type;
  logic            sys_clk_i = 1'b0;
  logic            arst_n_i;
  logic            tck_i;
  logic            tms_i;
  logic            tms_drive_i;
  logic            tdi_i;
  logic            tdi_drive_i;
  logic            tdo_o;
  logic            tdo_oe_o;
  logic [NPIN-1:0] pin_in_i;
  logic [NPIN-1:0] core_out_i;
  logic [NPIN-1:0] core_oe_i;
  logic [NPIN-1:0] pin_out_o;
  logic [NPIN-1:0] pin_oe_o;
  logic            drive_ready_i;
  logic            ext_test_o;
  logic [15:0]     seed_r = 16'hb605;
  logic [511:0]    pat;
  logic [511:0]    q;
  logic [511:0]    r;
  logic [2:0]      c;
  int              fail_count;
  int              n_tests;
  int              cyc_cnt;
  note_type        exp_q[$];
  logic [511:0]    got_q[$];
  wire  [511:0]    pins = 512'({pin_oe_o, pin_out_o});
  wire  [511:0]    core = 512'({core_oe_i, core_out_i});

  boundary_scan_tap #(.BSR_LEN(BSR)) u_dut (.*);
  scan_ctl u_ctl (
    .tck_o       (tck_i),
    .tms_o       (tms_i),
    .tms_drive_o (tms_drive_i),
    .tdi_o       (tdi_i),
    .tdi_drive_o (tdi_drive_i),
    .tdo_i       (tdo_o),
    .tdo_oe_i    (tdo_oe_o)
  );

  // system clock
  always #20 sys_clk_i = !sys_clk_i;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic rnd(output logic [511:0] v);
    for (int i = 0; i < 32; i++) begin
      seed_r = lfsr(seed_r);
      v[16*i +: 16] = seed_r;
    end
  endtask
  task automatic wait_sys(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input string nm, input logic [511:0] e, g);
    exp_q.push_back('{nm, e});
    got_q.push_back(g);
  endtask
  // chain image after capture: input, output, enable per pin
  function automatic logic [511:0] cap_exp();
    logic [511:0] e = '0;
    for (int k = 0; k < NPIN; k++) begin
      e[3*k]   = pin_in_i[k];
      e[3*k+1] = core_out_i[k];
      e[3*k+2] = core_oe_i[k];
    end
    return e;
  endfunction
  function automatic logic [511:0] drv_exp(input logic [511:0] p);
    logic [511:0] e = '0;
    for (int k = 0; k < NPIN; k++) begin
      e[k]      = p[3*k+1];
      e[NPIN+k] = p[3*k+2];
    end
    return e;
  endfunction
  task automatic new_pins;
    logic [511:0] a, b, d;
    rnd(a);
    rnd(b);
    rnd(d);
    @(negedge sys_clk_i);
    pin_in_i   = a[NPIN-1:0];
    core_out_i = b[NPIN-1:0];
    core_oe_i  = d[NPIN-1:0];
  endtask
  task automatic byp_chk;
    logic [511:0] d, g;
    rnd(d);
    new_pins();
    u_ctl.dr(8, d, g);
    chk("bypass", 512'({d[6:0], 1'b0}), g);
    wait_sys(3);
    chk("pins_core", core, pins);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare oldest note with each result seen
  always @(negedge sys_clk_i) begin
    note_type     n;
    logic [511:0] g;
    while (got_q.size() > 0) begin
      n = exp_q.pop_front();
      g = got_q.pop_front();
      n_tests++;
      if (g !== n.v) begin
        fail_count++;
        $display("Error %s expected %h seen %h", n.nm, n.v, g);
      end
    end
  end

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      fail_count++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    arst_n_i      = 1'b0;
    pin_in_i      = '0;
    core_out_i    = '0;
    core_oe_i     = '0;
    drive_ready_i = 1'b1;
    wait_sys(6);
    arst_n_i = 1'b1;
    u_ctl.idle(1);
    u_ctl.ir(scan_pkg::OP_BYPASS, c);
    chk("ir_capture", 512'(scan_pkg::IR_CAPTURE), 512'(c));
    byp_chk();
    for (int op = 1; op < 7; op++) begin
      if (op != 5) begin
        u_ctl.ir(3'(op), c);
        byp_chk();
      end
    end
    u_ctl.ir(scan_pkg::OP_SAMPLE, c);
    new_pins();
    u_ctl.idle(60);
    rnd(pat);
    u_ctl.dr(BSR, pat, r);
    chk("sample_capture", cap_exp(), r);
    wait_sys(10);
    chk("sample_pins", core, pins);
    u_ctl.ir(scan_pkg::OP_EXTEST, c);
    wait_sys(10);
    chk("ext_on", 512'(1), 512'(ext_test_o));
    chk("preload_pins", drv_exp(pat), pins);
    new_pins();
    u_ctl.idle(60);
    rnd(pat);
    u_ctl.dr(BSR, pat, r);
    chk("extest_capture", cap_exp(), r);
    wait_sys(10);
    chk("extest_pins", drv_exp(pat), pins);
    drive_ready_i = 1'b0;
    q = pat;
    for (int i = 0; i < 2; i++) begin
      rnd(pat);
      u_ctl.dr(BSR, pat, r);
    end
    wait_sys(10);
    chk("stalled_pins", drv_exp(q), pins);
    drive_ready_i = 1'b1;
    wait_sys(4);
    chk("drained_pins", drv_exp(pat), pins);
    u_ctl.float_reset(5);
    wait_sys(10);
    chk("ext_off", 512'(0), 512'(ext_test_o));
    u_ctl.idle(1);
    u_ctl.rel_tdi = 1'b1;
    u_ctl.dr(8, pat, r);
    chk("pulled_tdi", 512'(8'hfe), r);
    wait_sys(4);
    print_verdict();
  end
endmodule

// file: verif/scan_ctl.sv
// scan_ctl: board test controller model on the serial port
// assumes: test clock 12 ns, stands low between frames
`timescale 1ns/1ps
module scan_ctl (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tms_drive_o,
  output logic      tdi_o,
  output logic      tdi_drive_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  // --------------------------------------------------------------
  // levels and frame tasks
  // --------------------------------------------------------------
  logic rel_tdi = 1'b0;  // release serial in during frames

  // idle levels
  initial begin
    tck_o       = 1'b0;
    tms_o       = 1'b1;
    tms_drive_o = 1'b1;
    tdi_o       = 1'b0;
    tdi_drive_o = 1'b1;
  end

  // one test clock; a released line flips each cycle
  task automatic cyc(input logic m, input logic d, output logic o);
    tms_o       = tms_drive_o ? m : !tms_o;
    tdi_drive_o = !rel_tdi;
    tdi_o       = rel_tdi ? !tdi_o : d;
    #6;
    o     = tdo_oe_i ? tdo_i : !tdo_i;  // released line shows inverse
    tck_o = 1'b1;
    #6;
    tck_o = 1'b0;
  endtask

  task automatic idle(input int n);
    logic o;
    repeat (n) cyc(1'b0, 1'b0, o);
  endtask

  // three instruction bits, low bit first
  task automatic ir(input logic [2:0] op, output logic [2:0] c);
    logic o;
    cyc(1'b1, 1'b0, o);
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < 3; i++) cyc(i == 2, op[i], c[i]);
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask

  // data frame of exactly n bits
  task automatic dr(input int n, input logic [511:0] d,
                    output logic [511:0] q);
    logic o;
    q = '0;
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) cyc(i == n - 1, d[i], q[i]);
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask

  task automatic float_reset(input int n);
    logic o;
    tms_drive_o = 1'b0;
    repeat (n) cyc(1'b1, 1'b0, o);
    tms_drive_o = 1'b1;
  endtask
endmodule

// file: verif/scan_monitor.sv
// scan_monitor: concurrent checks on test port and pin paths
// assumes: bound into boundary_scan_tap; sees its ports only
`timescale 1ns/1ps
module scan_monitor #(
  parameter int NPIN = 91
) (
  input wire logic            sys_clk_i,
  input wire logic            arst_n_i,
  input wire logic            tck_i,
  input wire logic            tms_i,
  input wire logic            tms_drive_i,
  input wire logic            tdi_i,
  input wire logic            tdi_drive_i,
  input wire logic            tdo_o,
  input wire logic            tdo_oe_o,
  input wire logic [NPIN-1:0] core_out_i,
  input wire logic [NPIN-1:0] core_oe_i,
  input wire logic [NPIN-1:0] pin_out_o,
  input wire logic [NPIN-1:0] pin_oe_o,
  input wire logic            drive_ready_i,
  input wire logic            ext_test_o
);
  // --------------------------------------------------------------
  // shadow of port state and instruction
  // --------------------------------------------------------------
  scan_pkg::tap_state_type st_r;
  logic [2:0]              irs_r;
  logic [2:0]              ir_r;
  wire tms_e = tms_drive_i ? tms_i : 1'b1;  // undriven reads high
  wire tdi_e = tdi_drive_i ? tdi_i : 1'b1;
  wire byp = ir_r != scan_pkg::OP_EXTEST && ir_r != scan_pkg::OP_SAMPLE;
  wire shf = st_r == scan_pkg::SHIFT_IR || st_r == scan_pkg::SHIFT_DR;

  // state walk and instruction shadow
  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r  <= scan_pkg::TLR;
      irs_r <= 3'h0;
      ir_r  <= scan_pkg::OP_BYPASS;
    end else begin
      st_r <= scan_pkg::tap_next(st_r, tms_e);
      if (st_r == scan_pkg::SHIFT_IR) irs_r <= {tdi_e, irs_r[2:1]};
      if (st_r == scan_pkg::UPD_IR) ir_r <= irs_r;
      else if (st_r == scan_pkg::TLR) ir_r <= scan_pkg::OP_BYPASS;
    end
  end

  // reset state carried over to the system clock before use
  logic [1:0] tlr_s;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) tlr_s <= 2'b00;
    else tlr_s <= {tlr_s[0], st_r == scan_pkg::TLR};
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_oe_in_shift: assert property (
    @(posedge tck_i) disable iff (!arst_n_i) tdo_oe_o == shf)
    else $error("serial out enable outside shift state");
  a_ir_cap_lsb: assert property (
    @(posedge tck_i) disable iff (!arst_n_i)
    (st_r == scan_pkg::CAP_IR && !tms_e) |=> tdo_o)
    else $error("instruction capture low bit not one");
  a_ir_cap_next: assert property (
    @(posedge tck_i) disable iff (!arst_n_i)
    (st_r == scan_pkg::CAP_IR && !tms_e) ##1 !tms_e |=> !tdo_o)
    else $error("instruction capture second bit not zero");
  a_byp_cap_zero: assert property (
    @(posedge tck_i) disable iff (!arst_n_i)
    (st_r == scan_pkg::CAP_DR && byp && !tms_e) |=> !tdo_o)
    else $error("bypass capture not zero");
  a_byp_one_stage: assert property (
    @(posedge tck_i) disable iff (!arst_n_i)
    (st_r == scan_pkg::SHIFT_DR && byp) ##1 st_r == scan_pkg::SHIFT_DR
    |-> tdo_o == $past(tdi_e))
    else $error("bypass path not one stage");
  a_pins_follow: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    !ext_test_o ##1 !ext_test_o |-> pin_out_o == $past(core_out_i)
    && pin_oe_o == $past(core_oe_i))
    else $error("pins do not follow core outside external test");
  a_drive_hold: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ext_test_o && !drive_ready_i) [*2]
    |=> $stable(pin_out_o) && $stable(pin_oe_o))
    else $error("drive cells changed while drain stalled");
  a_reset_bypass: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    tlr_s[1] [*8] |-> !ext_test_o)
    else $error("external test held in reset state");

  c_byp_shift: cover property (@(posedge tck_i) shf && byp);
  c_ext_rise: cover property (@(posedge sys_clk_i) $rose(ext_test_o));
  c_ir_update: cover property (@(posedge tck_i) st_r == scan_pkg::UPD_IR);
endmodule

bind boundary_scan_tap scan_monitor #(.NPIN(NPIN)) u_mon (.*);
